// ### hdl/gpio_regs.vh
// Register map and field constants for the two-port GPIO block
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// ==========================================================
// Register byte offsets
`define OFF_A_DATA 12'h000
`define OFF_A_DIR 12'h004
`define OFF_A_PUE 12'h008
`define OFF_B_DATA 12'h00C
`define OFF_B_DIR 12'h010
`define OFF_B_PUE 12'h014
`define OFF_A_CFG 12'h018

// ==========================================================
// Widths, positions and reset values
`define A_PINS 6
`define B_PINS 8
`define A_PIN_TWO 2
`define CFG_IRQ_BIT 0
`define DIR_RESET 8'h00
`define PUE_RESET 8'h00
`define CFG_RESET 1'h0
`define WORD_ZERO 32'h00000000

`endif

// ### hdl/pin_sync.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;
  always @(posedge ref_clk) begin
    meta_r <= async_in;
    stable_r <= meta_r;
  end
  assign sync_out = stable_r;
endmodule // pin_sync
`default_nettype wire

// ### hdl/gpio_pin_ctrl.v
// Per-pin output, enable and pullup control for one port
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_ctrl #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] INPUT_ONLY = {WIDTH{1'b0}}
) (
  input wire [WIDTH-1:0] latch,
  input wire [WIDTH-1:0] dir,
  input wire [WIDTH-1:0] pue,
  input wire [WIDTH-1:0] pin_level,
  output wire [WIDTH-1:0] pad_out_nxt,
  output wire [WIDTH-1:0] pad_oe_nxt,
  output wire [WIDTH-1:0] pullup_nxt,
  output wire [WIDTH-1:0] read_val
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      assign pad_out_nxt[i] = latch[i];
      // Input-only pins never drive
      assign pad_oe_nxt[i] = dir[i] & ~INPUT_ONLY[i];
      // Pullup only while pin is an input
      assign pullup_nxt[i] = pue[i] & ~dir[i];
      assign read_val[i] = dir[i] ? latch[i] : pin_level[i];
    end
  endgenerate
endmodule // gpio_pin_ctrl
`default_nettype wire

// ### hdl/dual_gpio_port.v
// Two-port GPIO block with APB register access
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_regs.vh"
module dual_gpio_port #(
  parameter A_WIDTH = `A_PINS,
  parameter B_WIDTH = `B_PINS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [A_WIDTH-1:0] first_port_in,
  output reg [A_WIDTH-1:0] first_port_out,
  output reg [A_WIDTH-1:0] first_port_oe,
  output reg [A_WIDTH-1:0] first_port_pullup,
  input wire [B_WIDTH-1:0] second_port_in,
  output reg [B_WIDTH-1:0] second_port_out,
  output reg [B_WIDTH-1:0] second_port_oe,
  output reg [B_WIDTH-1:0] second_port_pullup
);

  // ========================================================
  // Register state
  reg [A_WIDTH-1:0] first_port_data_r;
  reg [A_WIDTH-1:0] first_port_direction_r;
  reg [A_WIDTH-1:0] first_port_pullup_enable_r;
  reg [B_WIDTH-1:0] second_port_data_r;
  reg [B_WIDTH-1:0] second_port_direction_r;
  reg [B_WIDTH-1:0] second_port_pullup_enable_r;
  reg irq_mode_r;
  reg pready_r;

  wire [A_WIDTH-1:0] a_pin_s;
  wire [B_WIDTH-1:0] b_pin_s;
  wire [A_WIDTH-1:0] a_out_nxt;
  wire [A_WIDTH-1:0] a_oe_nxt;
  wire [A_WIDTH-1:0] a_pu_nxt;
  wire [A_WIDTH-1:0] a_read;
  wire [B_WIDTH-1:0] b_out_nxt;
  wire [B_WIDTH-1:0] b_oe_nxt;
  wire [B_WIDTH-1:0] b_pu_nxt;
  wire [B_WIDTH-1:0] b_read;
  wire [A_WIDTH-1:0] a_read_mask;
  wire wr_en;
  wire lane0;
  reg [31:0] rdata_nxt;
  reg addr_ok;
  // Next register values
  reg [A_WIDTH-1:0] first_port_data_nxt;
  reg [A_WIDTH-1:0] first_port_direction_nxt;
  reg [A_WIDTH-1:0] first_port_pullup_enable_nxt;
  reg [B_WIDTH-1:0] second_port_data_nxt;
  reg [B_WIDTH-1:0] second_port_direction_nxt;
  reg [B_WIDTH-1:0] second_port_pullup_enable_nxt;
  reg irq_mode_nxt;
  reg sel_a_data;
  reg sel_a_dir;
  reg sel_a_pue;
  reg sel_b_data;
  reg sel_b_dir;
  reg sel_b_pue;
  reg sel_cfg;
  wire first_access;
  wire reg_write;

  // Reset values cut to the port widths
  localparam [7:0] DIR_RST = `DIR_RESET;
  localparam [7:0] PUE_RST = `PUE_RESET;

  // ========================================================
  // Pin synchronisers
  pin_sync #(.WIDTH(A_WIDTH)) u_sync_a (
    .ref_clk(ref_clk),
    .async_in(first_port_in),
    .sync_out(a_pin_s)
  );

  pin_sync #(.WIDTH(B_WIDTH)) u_sync_b (
    .ref_clk(ref_clk),
    .async_in(second_port_in),
    .sync_out(b_pin_s)
  );

  // ========================================================
  // Pin control
  // Fed with next values so the pins follow a write at its own edge
  gpio_pin_ctrl #(
    .WIDTH(A_WIDTH),
    .INPUT_ONLY({{(A_WIDTH-1){1'b0}}, 1'b1} << `A_PIN_TWO)
  ) u_ctrl_a (
    .latch(first_port_data_nxt),
    .dir(first_port_direction_nxt),
    .pue(first_port_pullup_enable_nxt),
    .pin_level(a_pin_s),
    .pad_out_nxt(a_out_nxt),
    .pad_oe_nxt(a_oe_nxt),
    .pullup_nxt(a_pu_nxt),
    .read_val(a_read)
  );

  gpio_pin_ctrl #(
    .WIDTH(B_WIDTH),
    .INPUT_ONLY({B_WIDTH{1'b0}})
  ) u_ctrl_b (
    .latch(second_port_data_nxt),
    .dir(second_port_direction_nxt),
    .pue(second_port_pullup_enable_nxt),
    .pin_level(b_pin_s),
    .pad_out_nxt(b_out_nxt),
    .pad_oe_nxt(b_oe_nxt),
    .pullup_nxt(b_pu_nxt),
    .read_val(b_read)
  );

  // Bit 2 forced low while external interrupt owns the pin
  assign a_read_mask = ~({{(A_WIDTH-1){1'b0}}, irq_mode_r}
    << `A_PIN_TWO);

  // ========================================================
  // APB slave: one wait state, answer in second access cycle
  assign wr_en = psel & penable & pready_r & pwrite & addr_ok;
  assign lane0 = pstrb[0];
  assign first_access = psel & penable & ~pready_r;
  assign reg_write = wr_en & lane0;
  assign pready = pready_r;

  // Address decode, one select per register
  always @* begin
    sel_a_data = 1'b0;
    sel_a_dir = 1'b0;
    sel_a_pue = 1'b0;
    sel_b_data = 1'b0;
    sel_b_dir = 1'b0;
    sel_b_pue = 1'b0;
    sel_cfg = 1'b0;
    addr_ok = 1'b1;
    if (paddr == `OFF_A_DATA) begin
      sel_a_data = 1'b1;
    end else if (paddr == `OFF_A_DIR) begin
      sel_a_dir = 1'b1;
    end else if (paddr == `OFF_A_PUE) begin
      sel_a_pue = 1'b1;
    end else if (paddr == `OFF_B_DATA) begin
      sel_b_data = 1'b1;
    end else if (paddr == `OFF_B_DIR) begin
      sel_b_dir = 1'b1;
    end else if (paddr == `OFF_B_PUE) begin
      sel_b_pue = 1'b1;
    end else if (paddr == `OFF_A_CFG) begin
      sel_cfg = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data, unused upper bits read zero
  always @* begin
    rdata_nxt = `WORD_ZERO;
    if (sel_a_data) begin
      rdata_nxt[A_WIDTH-1:0] = a_read & a_read_mask;
    end else if (sel_a_dir) begin
      rdata_nxt[A_WIDTH-1:0] = first_port_direction_r;
    end else if (sel_a_pue) begin
      rdata_nxt[A_WIDTH-1:0] = first_port_pullup_enable_r;
    end else if (sel_b_data) begin
      rdata_nxt[B_WIDTH-1:0] = b_read;
    end else if (sel_b_dir) begin
      rdata_nxt[B_WIDTH-1:0] = second_port_direction_r;
    end else if (sel_b_pue) begin
      rdata_nxt[B_WIDTH-1:0] = second_port_pullup_enable_r;
    end else if (sel_cfg) begin
      rdata_nxt[`CFG_IRQ_BIT] = irq_mode_r;
    end
  end

  // Ready handshake and read data capture
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata <= `WORD_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready_r <= first_access;
      if (first_access) begin
        pslverr <= ~addr_ok;
        prdata <= pwrite ? `WORD_ZERO : rdata_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ========================================================
  // Next register values, seen by the pins at the write edge
  always @* begin
    first_port_data_nxt = first_port_data_r;
    first_port_direction_nxt = first_port_direction_r;
    first_port_pullup_enable_nxt = first_port_pullup_enable_r;
    second_port_data_nxt = second_port_data_r;
    second_port_direction_nxt = second_port_direction_r;
    second_port_pullup_enable_nxt = second_port_pullup_enable_r;
    irq_mode_nxt = irq_mode_r;
    if (reg_write) begin
      if (sel_a_data) begin
        first_port_data_nxt = pwdata[A_WIDTH-1:0];
      end else if (sel_a_dir) begin
        first_port_direction_nxt = pwdata[A_WIDTH-1:0];
      end else if (sel_a_pue) begin
        first_port_pullup_enable_nxt = pwdata[A_WIDTH-1:0];
      end else if (sel_b_data) begin
        second_port_data_nxt = pwdata[B_WIDTH-1:0];
      end else if (sel_b_dir) begin
        second_port_direction_nxt = pwdata[B_WIDTH-1:0];
      end else if (sel_b_pue) begin
        second_port_pullup_enable_nxt = pwdata[B_WIDTH-1:0];
      end else if (sel_cfg) begin
        irq_mode_nxt = pwdata[`CFG_IRQ_BIT];
      end
    end
  end

  // ========================================================
  // Control registers with reset
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      first_port_direction_r <= DIR_RST[A_WIDTH-1:0];
      second_port_direction_r <= DIR_RST[B_WIDTH-1:0];
      first_port_pullup_enable_r <= PUE_RST[A_WIDTH-1:0];
      second_port_pullup_enable_r <= PUE_RST[B_WIDTH-1:0];
      irq_mode_r <= `CFG_RESET;
    end else begin
      first_port_direction_r <= first_port_direction_nxt;
      second_port_direction_r <= second_port_direction_nxt;
      first_port_pullup_enable_r <= first_port_pullup_enable_nxt;
      second_port_pullup_enable_r <= second_port_pullup_enable_nxt;
      irq_mode_r <= irq_mode_nxt;
    end
  end

  // ========================================================
  // Data latches: no reset, always writable
  always @(posedge ref_clk) begin
    first_port_data_r <= first_port_data_nxt;
    second_port_data_r <= second_port_data_nxt;
  end

  // ========================================================
  // Port A pin outputs, following the next register values
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      first_port_out <= {A_WIDTH{1'b0}};
      first_port_oe <= {A_WIDTH{1'b0}};
      first_port_pullup <= {A_WIDTH{1'b0}};
    end else begin
      first_port_out <= a_out_nxt;
      first_port_oe <= a_oe_nxt;
      first_port_pullup <= a_pu_nxt;
    end
  end

  // ========================================================
  // Port B pin outputs, following the next register values
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      second_port_out <= {B_WIDTH{1'b0}};
      second_port_oe <= {B_WIDTH{1'b0}};
      second_port_pullup <= {B_WIDTH{1'b0}};
    end else begin
      second_port_out <= b_out_nxt;
      second_port_oe <= b_oe_nxt;
      second_port_pullup <= b_pu_nxt;
    end
  end

endmodule // dual_gpio_port
`default_nettype wire

// ### dv/dual_gpio_port_assertions.sv
// Checker for the two-port GPIO block
`timescale 1ns/1ns
`default_nettype none
`include "gpio_regs.vh"
module gpio_chk #(
  parameter A_WIDTH = 6,
  parameter B_WIDTH = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire [A_WIDTH-1:0] first_port_oe,
  input wire [A_WIDTH-1:0] first_port_pullup,
  input wire [B_WIDTH-1:0] second_port_out,
  input wire [B_WIDTH-1:0] second_port_oe,
  input wire [B_WIDTH-1:0] second_port_pullup
);
  // ==========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wr = psel && penable && pready && pwrite && pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];
  AST_A2_IN: assert property (first_port_oe[2] == 1'h0)
    else $error("pin two drives");
  AST_A_PU: assert property ((first_port_pullup & first_port_oe) == 0)
    else $error("port A pullup on output");
  AST_B_PU: assert property ((second_port_pullup & second_port_oe) == 0)
    else $error("port B pullup on output");
  AST_RST: assert property ($rose(rst_n) |->
    second_port_oe == 0 && first_port_oe == 0)
    else $error("direction not cleared");
  AST_RDY: assert property ($rose(psel && penable) |=> pready)
    else $error("no answer");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_B_DIR: assert property (wr && paddr == `OFF_B_DIR |->
    ##1 second_port_oe == $past(wbyte))
    else $error("port B enable wrong");
  AST_B_DAT: assert property (wr && paddr == `OFF_B_DATA |->
    ##1 second_port_out == $past(wbyte))
    else $error("port B out wrong");
  AST_B_PUE: assert property (wr && paddr == `OFF_B_PUE |->
    ##1 second_port_pullup == ($past(wbyte) & ~second_port_oe))
    else $error("port B pullup wrong");
  cover property (wr && paddr == `OFF_B_DIR);
  cover property (pslverr);
  cover property (second_port_pullup != 0);
endmodule // gpio_chk
bind dual_gpio_port gpio_chk #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .first_port_oe(first_port_oe),
  .first_port_pullup(first_port_pullup), .second_port_out(second_port_out),
  .second_port_oe(second_port_oe), .second_port_pullup(second_port_pullup));
`default_nettype wire

// ### dv/board_pins.sv
// Board-side model of one port's pins
`timescale 1ns/1ns
`default_nettype none
module board_pins #(
  parameter W = 8
) (
  input wire logic ref_clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output wire logic [W-1:0] level
);
  logic flip = 1'h0;
  always @(posedge ref_clk) begin
    flip <= ~flip;
  end
  // Floating pins toggle so a stale value never passes
  assign level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pull_en | {W{flip}}));
endmodule // board_pins
`default_nettype wire

// ### dv/dual_gpio_port_tb_top.sv
// Self-checking bench for the two-port GPIO block
`timescale 1ns/1ns
`default_nettype none
`include "gpio_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module dual_gpio_port_tb_top;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, base;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] a_in, a_out, a_oe, a_pu;
  logic [7:0] b_in, b_out, b_oe, b_pu, en, ev, ext, dir, pue, dat, cfg;
  logic [7:0] m, oe, pu, ou, exp;
  int failures = 0;
  int num_checks = 0;
  int i, p;
  dual_gpio_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_port_in(a_in), .first_port_out(a_out), .first_port_oe(a_oe),
    .first_port_pullup(a_pu), .second_port_in(b_in), .second_port_out(b_out),
    .second_port_oe(b_oe), .second_port_pullup(b_pu));
  board_pins #(.W(6)) i_pa (.ref_clk(ref_clk), .pad_out(a_out), .pad_oe(a_oe),
    .pull_en(a_pu), .ext_en(en[5:0]), .ext_val(ev[5:0]), .level(a_in));
  board_pins #(.W(8)) i_pb (.ref_clk(ref_clk), .pad_out(b_out), .pad_oe(b_oe),
    .pull_en(b_pu), .ext_en(en), .ext_val(ev), .level(b_in));
  // ==========
  // Tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] d, r, u, e);
    return (r & d) | (~r & u) | (~r & ~u & e);
  endfunction
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, en, ev} = '0;
    i = $urandom(12);
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    `CHK(a_oe, 6'h00)
    `CHK(b_pu, 8'h00)
    apb(1'h0, `OFF_B_DIR, 8'h00);
    `CHK(rd[7:0], 8'h00)
    apb(1'h0, `OFF_A_DIR, 8'h00);
    `CHK(rd[7:0], 8'h00)
    apb(1'h1, 12'h01C, 8'hFF);
    `CHK(err, 1'h1)
    for (i = 0; i < 16; i++) begin
      for (p = 0; p < 2; p++) begin
        dat = 8'($urandom);
        dir = i == 0 ? 8'hFF : i < 3 ? 8'h00 : 8'($urandom);
        pue = i == 2 ? 8'hFF : i == 1 ? 8'h00 : 8'($urandom);
        cfg = 8'($urandom) & 8'h01;
        ext = 8'($urandom);
        en <= ~dir & ~pue;
        ev <= ext;
        m = p ? 8'hFF : 8'h3F & ~(dir & 8'h04);
        base = p ? `OFF_B_DATA : `OFF_A_DATA;
        if (p == 0) apb(1'h1, `OFF_A_CFG, cfg);
        apb(1'h1, base, dat);
        apb(1'h1, base + 12'h004, dir);
        apb(1'h1, base + 12'h008, pue);
        repeat (3) @(posedge ref_clk);
        oe = p ? b_oe : {2'h0, a_oe};
        pu = p ? b_pu : {2'h0, a_pu};
        ou = p ? b_out : {2'h0, a_out};
        `CHK(oe, dir & (p ? 8'hFF : 8'h3B))
        `CHK(pu & m, pue & ~dir & m)
        `CHK(ou & m, dat & m)
        apb(1'h0, base + 12'h008, 8'h00);
        `CHK(rd[7:0], pue & (p ? 8'hFF : 8'h3F))
        apb(1'h0, base, 8'h00);
        exp = exp_rd(dat, dir, pue, ext);
        if (p == 0 && cfg[0]) exp[2] = 1'h0;
        `CHK(rd[7:0] & m, exp & m)
      end
      $display("test %0d done", i);
    end
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
    `CHK(b_out, dat)
    `CHK(b_oe, 8'h00)
    $display("test reset done");
    end_of_test();
  end
endmodule // dual_gpio_port_tb_top
`default_nettype wire
